/* File: inc/dtm_pkg.sv */
// constants, commands and states of the memory timing controller
// assumes a single 40 MHz core clock; all figures are minimums

package dtm_pkg;

    // ********************************
    // clock and conversion
    // ********************************
    localparam int TCK_PS = 25000;  // core clock period in ps
    localparam int CNT_W  = 11;     // timer width, holds up to 2047 cycles

    // round a time in ps up to whole cycles, never below one
    function automatic int ps2cyc(input int ps);
        int c;
        c = (ps + TCK_PS - 1) / TCK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // larger of two cycle counts
    function automatic int maxi(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ********************************
    // timing figures
    // ********************************
    localparam int DLLK_CYC   = 768;
    localparam int MRD_CYC    = 8;
    localparam int MOD_NCK    = 24;
    localparam int MOD_PS     = 15000;
    localparam int MOD_CYC    = maxi(MOD_NCK, ps2cyc(MOD_PS));
    localparam int MPRR_CYC   = 1;
    localparam int CAL_NCK    = 3;
    localparam int CAL_PS     = 3748;
    localparam int CAL_CYC    = maxi(CAL_NCK, ps2cyc(CAL_PS));
    localparam int CPDED_CYC  = 4;
    localparam int MPE_CYC    = MOD_CYC + CPDED_CYC;
    localparam int ZQINIT_CYC = 1024;
    localparam int ZQOPER_CYC = 512;
    localparam int ZQCS_CYC   = 128;
    localparam int CKSR_NCK   = 5;
    localparam int CKSR_PS    = 10000;
    localparam int CKSR_CYC   = maxi(CKSR_NCK, ps2cyc(CKSR_PS));
    localparam int CKE_NCK    = 3;
    localparam int CKE_PS     = 5000;
    localparam int CKESR_CYC  = maxi(CKE_NCK, ps2cyc(CKE_PS)) + 1;
    localparam int XS_ADD_PS  = 10000;
    localparam int XPR_NCK    = 5;

    // ********************************
    // timer slots
    // ********************************
    localparam int TI_ANY   = 0;  // every command except exits, calibration and latency mode writes
    localparam int TI_FAST  = 1;  // calibration and latency mode writes
    localparam int TI_MRD   = 2;  // next mode write
    localparam int TI_MOD   = 3;  // commands after a mode write
    localparam int TI_DLL   = 4;  // commands needing a locked dll
    localparam int TI_CLK   = 5;  // clock must keep running
    localparam int TI_CKE   = 6;  // clock enable low time
    localparam int TI_CKX   = 7;  // clock stable before exits
    localparam int TI_BANK0 = 8;  // first per-bank reactivation slot

    // ********************************
    // commands and states
    // ********************************
    typedef enum logic [4:0] {
        CMD_NOP, CMD_RST_EXIT, CMD_MRS, CMD_MRS_FAST, CMD_MPR_WR,
        CMD_MPR_RD, CMD_ACT, CMD_WRA, CMD_RD, CMD_OTHER, CMD_ZQCL,
        CMD_ZQCS, CMD_SRE, CMD_SRX, CMD_SRX_ABORT, CMD_MAX_POWER_SAVE_STATE_ENT,
        CMD_MAX_POWER_SAVE_STATE_EXIT
    } dtm_cmd_e;

    typedef enum logic [1:0] {ST_RST, ST_RUN, ST_SR, ST_MAX_POWER_SAVE_STATE} dtm_state_e;

endpackage

/* File: inc/dtm_tmr_if.sv */
// load and done handshake between the controller and one delay timer
// assumes both ends run on the core clock

interface dtm_tmr_if import dtm_pkg::*; ();
    logic             load;
    logic [CNT_W-1:0] val;
    logic             done;

    modport ctl (output load, output val, input done);
    modport cnt (input load, input val, output done);
endinterface

/* File: logic/dtm_delay_timer.sv */
// one minimum-delay timer; a load never shortens a running wait
// assumes load values of at least one cycle

module dtm_delay_timer import dtm_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control side
    dtm_tmr_if.cnt   tmr
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] dec;
    logic [CNT_W-1:0] want;

    // count down, keep the longer of running and newly loaded wait
    always_comb begin
        dec       = (count_r == '0) ? '0 : count_r - CNT_W'(1);
        want      = (tmr.val == '0) ? '0 : tmr.val - CNT_W'(1);
        count_nxt = dec;
        if (tmr.load && (want > dec)) begin
            count_nxt = want;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign tmr.done = (count_r == '0);

endmodule // dtm_delay_timer

/* File: logic/dtm_timing_ctrl.sv */
// command scheduler that holds a memory device to its timing minimums
// assumes requests and configuration come from logic on core_clk
//
// Functional notes
// RQ1: after self refresh exit, dll commands wait 768 cycles
// RQ2: mode writes at least 8 cycles apart
// RQ3: after mode write, other commands wait max of 24 cycles and 15 ns
// RQ4: after a readout register access, allow one cycle recovery
// RQ5: after readout register write, wait update delay plus additive and parity latency
// RQ6: write with auto precharge blocks bank reactivation for recovery plus precharge
// RQ7: in select latency mode, select leads command by max of 3 cycles, 3.748 ns
// RQ8: device drops its command path after update delay plus pass disable delay
// RQ9: clock stays valid after power save entry for update plus disable delay
// RQ10: before power save exit, clock stable for the self refresh exit minimum
// RQ11: after power save exit, non-dll commands wait the self refresh exit delay
// RQ12: after power save exit, dll commands wait exit delay plus dll relock
// RQ13: allow 1024 cycles of calibration after reset before relying on drivers
// RQ14: long calibration needs 512 cycles before next command
// RQ15: short calibration needs 128 cycles before next command
// RQ16: after reset exit, wait max of 5 cycles and refresh time plus 10 ns
// RQ17: after self refresh exit, non-dll commands wait refresh time plus 10 ns
// RQ18: after aborted self refresh, non-dll commands wait short refresh plus 10 ns
// RQ19: calibration and latency mode writes may follow short refresh plus 10 ns
// RQ20: clock enable low in self refresh for pulse width plus one, plus parity
// RQ21: clock valid after self refresh entry max of 5 cycles, 10 ns, plus parity
// RQ22: clock valid before any exit for max of 5 cycles and 10 ns
// RQ23: command pass disable delay is at least 4 cycles
// RQ24: times round up to cycles, the larger minimum always wins

module dtm_timing_ctrl import dtm_pkg::*; #(
    parameter int RFC_PS  = 260000,  // refresh cycle time
    parameter int RFC4_PS = 160000,  // fine granularity refresh time
    parameter int RP_PS   = 15000,   // precharge time
    parameter int NBANK   = 16,
    parameter int BW      = $clog2(NBANK)
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    // command request
    input  wire logic          reqValid,
    input  wire dtm_cmd_e      reqCmd,
    input  wire logic [BW-1:0] reqBank,
    output logic               reqAck,
    // configuration
    input  wire logic          cfgCalEn,
    input  wire logic          cfgParEn,
    input  wire logic [4:0]    cfgWr,
    input  wire logic [4:0]    cfgAl,
    input  wire logic [3:0]    cfgPl,
    input  wire logic          clkStopReq,
    // memory pins
    output logic               memCkEn,
    output logic               memCke,
    output logic               memCsN,
    output logic               memCmdValid,
    output dtm_cmd_e           memCmd,
    output logic [BW-1:0]      memBank,
    // status
    output dtm_state_e         memState
);

    // ********************************
    // derived waits
    // ********************************
    localparam int NT      = TI_BANK0 + NBANK;
    localparam int XS_CYC  = ps2cyc(RFC_PS + XS_ADD_PS); // RQ24
    localparam int XPR_CYC = maxi(XPR_NCK, XS_CYC);
    localparam int XSF_CYC = ps2cyc(RFC4_PS + XS_ADD_PS);
    localparam int RP_CYC  = ps2cyc(RP_PS);
    localparam int CAL_A   = CAL_CYC;

    // ********************************
    // declarations
    // ********************************
    logic [NT-1:0]    dn;
    logic [NT-1:0]    ld;
    logic [CNT_W-1:0] lv [NT];

    dtm_state_e      state_r, state_nxt;
    logic            ack_r, ack_nxt;
    logic            ckEn_r, ckEn_nxt;
    logic            cke_r, cke_nxt;
    logic            csN_r, csN_nxt;
    logic            cmdV_r, cmdV_nxt;
    dtm_cmd_e        cmd_r, cmd_nxt;
    logic [BW-1:0]   bank_r, bank_nxt;
    logic [1:0]      lead_r, lead_nxt;
    dtm_cmd_e        pend_r, pend_nxt;
    logic [BW-1:0]   pBank_r, pBank_nxt;
    logic            zqInit_r, zqInit_nxt;
    logic            first_r;

    logic            ok;
    logic            take;
    logic            iss;
    dtm_cmd_e        issCmd;
    logic [BW-1:0]   issBank;
    logic            run;
    logic [CNT_W-1:0] parX;

    // ********************************
    // timers
    // ********************************
    dtm_tmr_if tif [NT] ();

    // one timer per slot
    generate
        for (genvar i = 0; i < NT; i++) begin : g_tmr
            assign tif[i].load = ld[i];
            assign tif[i].val  = lv[i];
            assign dn[i]       = tif[i].done;
            dtm_delay_timer u_tmr (
                .core_clk (core_clk),
                .rstn     (rstn),
                .tmr      (tif[i])
            );
        end
    endgenerate

    // ********************************
    // request check
    // ********************************
    assign run = (state_r == ST_RUN);

    // which waits gate each command
    always_comb begin
        ok = 1'b0;
        case (reqCmd)
            CMD_RST_EXIT: begin
                ok = (state_r == ST_RST) && ckEn_r && dn[TI_CKX]; // RQ22
            end
            CMD_MRS, CMD_MPR_WR, CMD_MAX_POWER_SAVE_STATE_ENT: begin
                ok = run && dn[TI_ANY] && dn[TI_MRD]; // RQ2
            end
            CMD_MRS_FAST: begin
                ok = run && dn[TI_FAST] && dn[TI_MRD]; // RQ19
            end
            CMD_ZQCL, CMD_ZQCS: begin
                ok = run && dn[TI_FAST] && dn[TI_MOD]; // RQ19
            end
            CMD_ACT: begin
                ok = run && dn[TI_ANY] && dn[TI_MOD]
                     && dn[TI_BANK0 + int'(reqBank)]; // RQ6
            end
            CMD_WRA, CMD_RD, CMD_MPR_RD: begin
                ok = run && dn[TI_ANY] && dn[TI_MOD] && dn[TI_DLL]; // RQ1
            end
            CMD_OTHER, CMD_SRE: begin
                ok = run && dn[TI_ANY] && dn[TI_MOD]; // RQ3
            end
            CMD_SRX, CMD_SRX_ABORT: begin
                ok = (state_r == ST_SR) && dn[TI_CKE] && ckEn_r && dn[TI_CKX]; // RQ20
            end
            CMD_MAX_POWER_SAVE_STATE_EXIT: begin
                ok = (state_r == ST_MAX_POWER_SAVE_STATE) && ckEn_r && dn[TI_CKX]; // RQ10
            end
            default: begin
                ok = 1'b0;
            end
        endcase
    end

    // take a request, issue now or after the select lead
    assign take    = reqValid && !ack_r && (lead_r == 2'd0) && ok;
    assign iss     = (take && !cfgCalEn) || (lead_r == 2'd1); // RQ7
    assign issCmd  = (lead_r == 2'd1) ? pend_r : reqCmd;
    assign issBank = (lead_r == 2'd1) ? pBank_r : reqBank;
    assign parX    = cfgParEn ? CNT_W'(cfgPl) : '0;

    // ********************************
    // timer loads
    // ********************************
    // each issued command starts the waits it owes
    always_comb begin
        ld = '0;
        for (int k = 0; k < NT; k++) begin
            lv[k] = '0;
        end
        if (iss) begin
            case (issCmd)
                CMD_RST_EXIT: begin
                    ld[TI_ANY]  = 1'b1; // RQ16
                    lv[TI_ANY]  = CNT_W'(XPR_CYC);
                    ld[TI_FAST] = 1'b1;
                    lv[TI_FAST] = CNT_W'(XPR_CYC);
                    ld[TI_DLL]  = 1'b1;
                    lv[TI_DLL]  = CNT_W'(DLLK_CYC);
                end
                CMD_MRS, CMD_MRS_FAST: begin
                    ld[TI_MRD] = 1'b1; // RQ2
                    lv[TI_MRD] = CNT_W'(MRD_CYC);
                    ld[TI_MOD] = 1'b1; // RQ3
                    lv[TI_MOD] = CNT_W'(MOD_CYC);
                end
                CMD_MPR_WR: begin
                    ld[TI_MRD] = 1'b1;
                    lv[TI_MRD] = CNT_W'(MRD_CYC);
                    ld[TI_MOD] = 1'b1; // RQ5
                    lv[TI_MOD] = CNT_W'(MOD_CYC) + CNT_W'(cfgAl) + CNT_W'(cfgPl);
                end
                CMD_MAX_POWER_SAVE_STATE_ENT: begin
                    ld[TI_MRD] = 1'b1;
                    lv[TI_MRD] = CNT_W'(MRD_CYC);
                    ld[TI_MOD] = 1'b1;
                    lv[TI_MOD] = CNT_W'(MOD_CYC);
                    ld[TI_CLK] = 1'b1; // RQ9
                    lv[TI_CLK] = CNT_W'(MPE_CYC); // RQ23
                end
                CMD_MPR_RD: begin
                    ld[TI_ANY]  = 1'b1; // RQ4
                    lv[TI_ANY]  = CNT_W'(MPRR_CYC);
                    ld[TI_FAST] = 1'b1;
                    lv[TI_FAST] = CNT_W'(MPRR_CYC);
                end
                CMD_WRA: begin
                    ld[TI_BANK0 + int'(issBank)] = 1'b1; // RQ6
                    lv[TI_BANK0 + int'(issBank)] = CNT_W'(cfgWr) + CNT_W'(RP_CYC);
                end
                CMD_ZQCL: begin
                    ld[TI_ANY]  = 1'b1; // RQ14
                    lv[TI_ANY]  = zqInit_r ? CNT_W'(ZQINIT_CYC) : CNT_W'(ZQOPER_CYC); // RQ13
                    ld[TI_FAST] = 1'b1;
                    lv[TI_FAST] = lv[TI_ANY];
                end
                CMD_ZQCS: begin
                    ld[TI_ANY]  = 1'b1; // RQ15
                    lv[TI_ANY]  = CNT_W'(ZQCS_CYC);
                    ld[TI_FAST] = 1'b1;
                    lv[TI_FAST] = CNT_W'(ZQCS_CYC);
                end
                CMD_SRE: begin
                    ld[TI_CKE] = 1'b1; // RQ20
                    lv[TI_CKE] = CNT_W'(CKESR_CYC) + parX;
                    ld[TI_CLK] = 1'b1; // RQ21
                    lv[TI_CLK] = CNT_W'(CKSR_CYC) + parX;
                end
                CMD_SRX: begin
                    ld[TI_ANY]  = 1'b1; // RQ17
                    lv[TI_ANY]  = CNT_W'(XS_CYC);
                    ld[TI_FAST] = 1'b1; // RQ19
                    lv[TI_FAST] = CNT_W'(XSF_CYC);
                    ld[TI_DLL]  = 1'b1; // RQ1
                    lv[TI_DLL]  = CNT_W'(DLLK_CYC);
                end
                CMD_SRX_ABORT: begin
                    ld[TI_ANY]  = 1'b1; // RQ18
                    lv[TI_ANY]  = CNT_W'(XSF_CYC);
                    ld[TI_FAST] = 1'b1;
                    lv[TI_FAST] = CNT_W'(XSF_CYC);
                    ld[TI_DLL]  = 1'b1;
                    lv[TI_DLL]  = CNT_W'(DLLK_CYC);
                end
                CMD_MAX_POWER_SAVE_STATE_EXIT: begin
                    ld[TI_ANY]  = 1'b1; // RQ11
                    lv[TI_ANY]  = CNT_W'(XS_CYC);
                    ld[TI_FAST] = 1'b1;
                    lv[TI_FAST] = CNT_W'(XS_CYC);
                    ld[TI_DLL]  = 1'b1; // RQ12
                    lv[TI_DLL]  = CNT_W'(XS_CYC + DLLK_CYC);
                end
                default: begin
                    ld[TI_ANY] = 1'b0;
                end
            endcase
        end
        // clock-stable wait restarts while the clock is stopped
        ld[TI_CKX] = !ckEn_r || first_r; // RQ22
        lv[TI_CKX] = CNT_W'(CKSR_CYC);
    end

    // ********************************
    // control and pins
    // ********************************
    // state, clock gating, select lead and pin drive
    always_comb begin
        state_nxt  = state_r;
        ack_nxt    = take;
        csN_nxt    = !take; // RQ7
        cmdV_nxt   = iss;
        cmd_nxt    = iss ? issCmd : CMD_NOP;
        bank_nxt   = iss ? issBank : bank_r;
        pend_nxt   = take ? reqCmd : pend_r;
        pBank_nxt  = take ? reqBank : pBank_r;
        zqInit_nxt = zqInit_r && !(iss && issCmd == CMD_ZQCL);
        lead_nxt   = (lead_r != 2'd0) ? lead_r - 2'd1 : lead_r;
        if (take && cfgCalEn) begin
            lead_nxt = 2'(CAL_CYC); // RQ7
        end
        if (iss) begin
            case (issCmd)
                CMD_RST_EXIT, CMD_SRX, CMD_SRX_ABORT, CMD_MAX_POWER_SAVE_STATE_EXIT: begin
                    state_nxt = ST_RUN;
                end
                CMD_SRE: begin
                    state_nxt = ST_SR;
                end
                CMD_MAX_POWER_SAVE_STATE_ENT: begin
                    state_nxt = ST_MAX_POWER_SAVE_STATE;
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
        cke_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_MAX_POWER_SAVE_STATE);
        // stop only when parked and the post-entry clock wait is over
        if (ckEn_r) begin
            ckEn_nxt = !(clkStopReq && dn[TI_CLK]
                         && (state_r == ST_SR || state_r == ST_MAX_POWER_SAVE_STATE)); // RQ21
        end else begin
            ckEn_nxt = !clkStopReq;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r  <= ST_RST;
            ack_r    <= 1'b0;
            ckEn_r   <= 1'b1;
            cke_r    <= 1'b0;
            csN_r    <= 1'b1;
            cmdV_r   <= 1'b0;
            cmd_r    <= CMD_NOP;
            bank_r   <= '0;
            lead_r   <= 2'd0;
            pend_r   <= CMD_NOP;
            pBank_r  <= '0;
            zqInit_r <= 1'b1;
            first_r  <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            ack_r    <= ack_nxt;
            ckEn_r   <= ckEn_nxt;
            cke_r    <= cke_nxt;
            csN_r    <= csN_nxt;
            cmdV_r   <= cmdV_nxt;
            cmd_r    <= cmd_nxt;
            bank_r   <= bank_nxt;
            lead_r   <= lead_nxt;
            pend_r   <= pend_nxt;
            pBank_r  <= pBank_nxt;
            zqInit_r <= zqInit_nxt;
            first_r  <= 1'b0;
        end
    end

    // outputs straight from flops
    assign reqAck      = ack_r;
    assign memCkEn     = ckEn_r;
    assign memCke      = cke_r;
    assign memCsN      = csN_r;
    assign memCmdValid = cmdV_r;
    assign memCmd      = cmd_r;
    assign memBank     = bank_r;
    assign memState    = state_r;

    // ********************************
    // checks
    // ********************************
    logic [CNT_W-1:0] sMrs_r, sMrs_nxt;
    logic [CNT_W-1:0] sExit_r, sExit_nxt;
    logic [CNT_W-1:0] sEnt_r, sEnt_nxt;
    logic [CNT_W-1:0] ckeLow_r, ckeLow_nxt;
    logic [CNT_W-1:0] ckOn_r, ckOn_nxt;
    logic             mrsOut, depOut, dllOut, exitOut, entOut;

    // classes of commands seen on the pins
    always_comb begin
        mrsOut  = cmdV_r && (cmd_r inside {CMD_MRS, CMD_MRS_FAST, CMD_MPR_WR, CMD_MAX_POWER_SAVE_STATE_ENT});
        depOut  = cmdV_r && !mrsOut;
        dllOut  = cmdV_r && (cmd_r inside {CMD_WRA, CMD_RD, CMD_MPR_RD});
        exitOut = cmdV_r && (cmd_r inside {CMD_RST_EXIT, CMD_SRX, CMD_SRX_ABORT,
                                           CMD_MAX_POWER_SAVE_STATE_EXIT});
        entOut  = cmdV_r && (cmd_r inside {CMD_SRE, CMD_MAX_POWER_SAVE_STATE_ENT});
        sMrs_nxt   = mrsOut ? CNT_W'(1) : (&sMrs_r ? sMrs_r : sMrs_r + CNT_W'(1));
        sExit_nxt  = exitOut ? CNT_W'(1) : (&sExit_r ? sExit_r : sExit_r + CNT_W'(1));
        sEnt_nxt   = entOut ? CNT_W'(1) : (&sEnt_r ? sEnt_r : sEnt_r + CNT_W'(1));
        ckeLow_nxt = cke_r ? '0 : (&ckeLow_r ? ckeLow_r : ckeLow_r + CNT_W'(1));
        ckOn_nxt   = !ckEn_r ? '0 : (&ckOn_r ? ckOn_r : ckOn_r + CNT_W'(1));
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sMrs_r   <= '1;
            sExit_r  <= '0;
            sEnt_r   <= '1;
            ckeLow_r <= '0;
            ckOn_r   <= '0;
        end else begin
            sMrs_r   <= sMrs_nxt;
            sExit_r  <= sExit_nxt;
            sEnt_r   <= sEnt_nxt;
            ckeLow_r <= ckeLow_nxt;
            ckOn_r   <= ckOn_nxt;
        end
    end

    AST_MRD_SPACING: assert property (@(posedge core_clk) disable iff (!rstn) // RQ2
        mrsOut |=> !mrsOut [*7]) else $error("mode writes closer than 8 cycles");

    AST_MOD_WAIT: assert property (@(posedge core_clk) disable iff (!rstn) // RQ3
        depOut |-> sMrs_r >= CNT_W'(MOD_CYC)) else $error("command inside mode update");

    AST_DLL_WAIT: assert property (@(posedge core_clk) disable iff (!rstn) // RQ1
        dllOut |-> sExit_r >= CNT_W'(DLLK_CYC)) else $error("dll command before lock");

    AST_CKE_LOW: assert property (@(posedge core_clk) disable iff (!rstn) // RQ20
        $rose(cke_r) |-> ckeLow_r >= CNT_W'(CKESR_CYC)) else $error("clock enable low too short");

    AST_CAL_LEAD: assert property (@(posedge core_clk) disable iff (!rstn) // RQ7
        cmdV_r && cfgCalEn && $past(cfgCalEn, CAL_A) |-> !$past(csN_r, CAL_A))
        else $error("select does not lead command");

    AST_CLK_SRE: assert property (@(posedge core_clk) disable iff (!rstn) // RQ21
        cmdV_r && cmd_r == CMD_SRE |-> ckEn_r [*5]) else $error("clock stopped after entry");

    AST_CLK_EXIT: assert property (@(posedge core_clk) disable iff (!rstn) // RQ22
        exitOut |-> ckOn_r >= CNT_W'(CKSR_CYC)) else $error("clock not stable before exit");

    AST_MAX_POWER_SAVE_STATE_CLK: assert property (@(posedge core_clk) disable iff (!rstn) // RQ9
        $fell(ckEn_r) && state_r == ST_MAX_POWER_SAVE_STATE |-> sEnt_r >= CNT_W'(MPE_CYC))
        else $error("clock stopped early in power save");

endmodule // dtm_timing_ctrl

/* File: test/dtm_dev_model.sv */
// device side model: command path gating, mode write spacing, clock hold
// assumes the pins are sampled on the core clock rising edge
module dtm_dev_model import dtm_pkg::*; (
    // clock and pins
    input wire logic     core_clk,
    input wire logic     memCkEn,
    input wire logic     memCmdValid,
    input wire dtm_cmd_e memCmd,
    // broken minimums seen
    output int           bad = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    int sinceMrs = 99;
    int sinceEnt = -1;
    // count spacing faults on the pins
    always @(posedge core_clk) begin
        sinceMrs++;
        if (sinceEnt >= 0) sinceEnt++;
        if (!memCkEn && sinceEnt >= 0 && sinceEnt < MPE_CYC) bad++;
        if (memCmdValid) begin
            if (memCmd == CMD_MRS && sinceMrs < MRD_CYC) bad++;
            if (sinceEnt >= MPE_CYC && memCmd != CMD_MAX_POWER_SAVE_STATE_EXIT) bad++;
            if (memCmd == CMD_MRS) sinceMrs = 0;
            if (memCmd == CMD_MAX_POWER_SAVE_STATE_ENT) sinceEnt = 0;
            if (memCmd == CMD_MAX_POWER_SAVE_STATE_EXIT) sinceEnt = -1;
        end
    end
endmodule // dtm_dev_model

/* File: test/testbench.sv */
// timing controller bench: command spacing measured at the pins
// assumes a 40 MHz core clock and the device model beside the pins
module testbench import dtm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rstn = 0, reqValid = 0, reqAck, cfgCalEn = 0, clkStopReq = 0;
    logic memCkEn, memCke, memCsN, memCmdValid;
    dtm_cmd_e reqCmd = CMD_NOP, memCmd;
    dtm_state_e memState;
    logic [3:0] reqBank = '0, memBank;
    int n_errors = 0, checked = 0, cyc = 0, lastIss = 0, gap = 0, nIss = 0, csCyc = 0;
    int ckOff = 0, ckOn = 0, bad;
    dtm_timing_ctrl i_dtm_timing_ctrl (.core_clk, .rstn, .reqValid, .reqCmd, .reqBank,
        .reqAck, .cfgCalEn, .cfgParEn(1'b0), .cfgWr(5'h0a), .cfgAl(5'h02), .cfgPl(4'h1),
        .clkStopReq, .memCkEn, .memCke, .memCsN, .memCmdValid, .memCmd, .memBank, .memState);
    dtm_dev_model i_dtm_dev_model (.core_clk, .memCkEn, .memCmdValid, .memCmd, .bad);
    // clock
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // pin monitor, issue gaps and clock stop times
    always @(negedge core_clk) begin
        cyc++;
        if (memCmdValid === 1) begin
            gap = cyc - lastIss;
            lastIss = cyc;
            nIss++;
        end
        if (memCsN === 0) csCyc = cyc;
        if (memCkEn === 0 && ckOff <= ckOn) ckOff = cyc;
        if (memCkEn === 1 && ckOff > ckOn) ckOn = cyc;
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // one request, then the gap since the previous command
    task automatic step(dtm_cmd_e c, logic [3:0] b, int e);
        int n;
        int k;
        k = nIss;
        n = 0;
        @(posedge core_clk);
        reqValid <= 1;
        reqCmd <= c;
        reqBank <= b;
        while (reqAck !== 1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        reqValid <= 0;
        while (nIss == k && n < 3010) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 3000) chk("request ack", 1, 0);
        if (e != 0) chk(c.name(), e, gap);
    endtask
    task automatic t_init();
        repeat (5) @(negedge core_clk);
        chk("cke in reset", 0, memCke);
        chk("cs in reset", 1, memCsN);
        @(posedge core_clk);
        rstn <= 1;
        step(CMD_RST_EXIT, 0, 0);
        step(CMD_MRS, 0, 11);
        step(CMD_MRS, 0, 8);
        step(CMD_OTHER, 0, 24);
        step(CMD_ZQCL, 0, 0);
        step(CMD_OTHER, 0, 1024);
        step(CMD_ZQCL, 0, 0);
        step(CMD_OTHER, 0, 512);
        step(CMD_ZQCS, 0, 0);
        step(CMD_OTHER, 0, 128);
    endtask
    task automatic t_mpr_bank();
        step(CMD_MPR_WR, 0, 0);
        step(CMD_OTHER, 0, 24 + 2 + 1);
        step(CMD_WRA, 4'h5, 0);
        step(CMD_ACT, 4'h5, 10 + 1);
        chk("bank", 5, memBank);
    endtask
    task automatic t_sref();
        step(CMD_SRE, 0, 0);
        chk("state", ST_SR, memState);
        step(CMD_SRX, 0, 0);
        step(CMD_MRS_FAST, 0, 7);
        step(CMD_SRE, 0, 0);
        step(CMD_SRX_ABORT, 0, 0);
        step(CMD_OTHER, 0, 7);
        step(CMD_SRE, 0, 0);
        step(CMD_SRX, 0, 0);
        step(CMD_OTHER, 0, 11);
        step(CMD_RD, 0, 768 - 11);
    endtask
    task automatic t_max_power_save_state();
        int ent;
        step(CMD_MAX_POWER_SAVE_STATE_ENT, 0, 0);
        ent = lastIss;
        chk("state", ST_MAX_POWER_SAVE_STATE, memState);
        @(posedge core_clk);
        clkStopReq <= 1;
        repeat (60) @(posedge core_clk);
        clkStopReq <= 0;
        step(CMD_MAX_POWER_SAVE_STATE_EXIT, 0, 0);
        chk("clock held", 1, ckOff - ent >= MPE_CYC);
        chk("clock before exit", 1, lastIss - ckOn >= CKSR_CYC);
        step(CMD_OTHER, 0, 11);
        step(CMD_RD, 0, 779 - 11);
    endtask
    task automatic t_lead();
        @(posedge core_clk);
        cfgCalEn <= 1;
        step(CMD_OTHER, 0, 0);
        chk("select lead", CAL_CYC, lastIss - csCyc);
        @(posedge core_clk);
        cfgCalEn <= 0;
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        t_init();
        t_mpr_bank();
        t_sref();
        t_max_power_save_state();
        t_lead();
        chk("device faults", 0, bad);
        finish_test();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end
endmodule // testbench
